// *** design/amo_map.vh ***
`ifndef AMO_MAP_VH
`define AMO_MAP_VH
// parameter addresses (16-bit word addresses as printed)
`define AMO_ADDR_SRC      16'h0006
`define AMO_ADDR_POL      16'h0106
`define AMO_ADDR_PROP_A   16'h0108
`define AMO_ADDR_PROP_B   16'h010a
`define AMO_ADDR_DRIFT_A  16'h0428
`define AMO_ADDR_DRIFT_B  16'h042a
// reset values
`define AMO_RST_SRC       16'h0000
`define AMO_RST_POL       16'h0000
`define AMO_RST_PROP      16'h0064
`define AMO_RST_DRIFT     16'h0000
// parameter reset command value that spares the drift offsets
`define AMO_KEEP_DRIFT    16'h000a
// scaling
`define AMO_FULL_MV       17'sh01f40
`define AMO_LIMIT_MV      18'sh01f40
`define AMO_PCT_FULL      8'h64
`define AMO_DRIFT_MAX     16'sh0320
`define AMO_DAC_MID       10'h200
`define AMO_DAC_MAX       10'h3ff
`define AMO_DAC_MIN       10'h000
// code = mv * 512 / 8000 ~= mv * 4194 >> 16 (~15.6 mv/step)
`define AMO_DAC_MUL       14'h1062
`define AMO_DAC_SHIFT     16
`define AMO_CODE_HI       34'sh1ff
`define AMO_CODE_LO       (-34'sh200)
`define AMO_CODE_W        10
// q1.15 inputs and millivolt rails
`define AMO_NORM_SHIFT    15
`define AMO_NORM_MAX      16'sh7fff
`define AMO_NORM_MIN      16'sh8000
`define AMO_NORM_ZERO     16'h0000
`define AMO_RAIL_MV       34'sh1f40
`define AMO_ZERO_MV       34'sh0
`define AMO_PCT_ZERO      8'h00
// field positions and channel layout
`define AMO_REG_W         16
`define AMO_CHANNELS      2
`define AMO_SRC_DIGIT_W   4
`define AMO_SRC_SEL_W     3
`define AMO_POL_INV_A     1
`define AMO_POL_INV_B     0
`define AMO_POL_PULSE     4
`define AMO_RST_RDATA     16'h0000
// source codes
`define AMO_SRC_SPEED     3'h0
`define AMO_SRC_TORQUE    3'h1
`define AMO_SRC_PULSE     3'h2
`define AMO_SRC_SPD_CMD   3'h3
`define AMO_SRC_TRQ_CMD   3'h4
`define AMO_SRC_VBUS      3'h5
`endif

// *** design/amo_channel.v ***
`timescale 1ns/1ps
`include "amo_map.vh"
// one monitor channel: polarity, proportion, drift offset, clamp, dac code
module amo_channel (
   input  wire               i_core_clk,
   input  wire               i_rst,
   input  wire signed [15:0] i_norm,
   input  wire               i_invert,
   input  wire        [15:0] i_prop,
   input  wire        [15:0] i_drift,
   output reg         [9:0]  o_code
);
   // i_norm is quantity/max in q1.15 (32767 = full scale)
   reg signed [15:0] signed_q;
   reg signed [33:0] mv_raw;
   reg signed [33:0] mv_scaled;
   reg signed [33:0] mv_off;
   reg signed [17:0] mv_sat;
   reg signed [33:0] code_wide;
   reg        [9:0]  code_d;
   reg        [7:0]  pct;
   reg signed [15:0] drift_c;

   always @* begin
      // negating the most negative input would wrap, so it is pinned to +full scale
      if (!i_invert)
         signed_q = i_norm;
      else if (i_norm == `AMO_NORM_MIN)
         signed_q = `AMO_NORM_MAX;
      else
         signed_q = -i_norm;
      mv_raw   = signed_q * `AMO_FULL_MV;
      // zero proportion means an infinite gain: a nonzero input sets the scaled value to its rail, a zero input to 0 mV, before the drift offset is added
      pct = (i_prop > {8'h00, `AMO_PCT_FULL}) ? `AMO_PCT_FULL : i_prop[7:0];
      if (pct == `AMO_PCT_ZERO)
         mv_scaled = (signed_q < 0) ? -`AMO_RAIL_MV : ((signed_q > 0) ? `AMO_RAIL_MV : `AMO_ZERO_MV);
      else
         mv_scaled = ((mv_raw >>> `AMO_NORM_SHIFT) * $signed({1'b0, `AMO_PCT_FULL})) / $signed({26'd0, pct});
      drift_c = $signed(i_drift);
      if (drift_c > `AMO_DRIFT_MAX)
         drift_c = `AMO_DRIFT_MAX;
      else if (drift_c < -`AMO_DRIFT_MAX)
         drift_c = -`AMO_DRIFT_MAX;
      mv_off = mv_scaled + drift_c;
      if (mv_off > `AMO_LIMIT_MV)
         mv_sat = `AMO_LIMIT_MV;
      else if (mv_off < -`AMO_LIMIT_MV)
         mv_sat = -`AMO_LIMIT_MV;
      else
         mv_sat = mv_off[17:0];
      code_wide = (mv_sat * $signed({1'b0, `AMO_DAC_MUL})) >>> `AMO_DAC_SHIFT;
      if (code_wide > `AMO_CODE_HI)
         code_d = `AMO_DAC_MAX;
      else if (code_wide < `AMO_CODE_LO)
         code_d = `AMO_DAC_MIN;
      else
         code_d = code_wide[9:0] ^ `AMO_DAC_MID;
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_code <= `AMO_DAC_MID;
      else
         o_code <= code_d;
   end
endmodule

// *** design/amo_monitor.v ***
// Contract
// - source 0 shows motor speed, full speed at +/-8 V
// - source 1 shows motor torque, full torque at +/-8 V
// - source 2 shows pulse frequency, positive only, 8 V at 4.5 Mpps
// - source 3 shows speed command, full command at +/-8 V
// - source 4 shows torque command, full command at +/-8 V
// - source 5 shows bus voltage, 450 V at 8 V; 6 and 7 reserved
// - source select low digit is channel a, next digit channel b
// - polarity low digit: 0 none, 1 invert b, 2 invert a, 3 both
// - polarity second digit: 0 forward, 1 reverse pulse output
// - output is 8 V times quantity over max times proportion/100; the code multiplies by 100/proportion instead
// - per channel drift offset of -800..800 mV is added
// - parameter reset with value 10 keeps both drift offsets
// - output is clamped to +/-8 V
// - each channel drives a 10-bit converter code
`timescale 1ns/1ps
`include "amo_map.vh"
module amo_monitor (
   input  wire        i_core_clk,
   input  wire        i_rst,
   input  wire        i_par_wr,
   input  wire [15:0] i_par_addr,
   input  wire [15:0] i_par_wdata,
   output reg  [15:0] o_par_rdata,
   input  wire        i_param_reset,
   input  wire [15:0] i_param_reset_value,
   input  wire [15:0] i_motor_speed,
   input  wire [15:0] i_motor_torque,
   input  wire [15:0] i_pulse_freq,
   input  wire [15:0] i_speed_cmd,
   input  wire [15:0] i_torque_cmd,
   input  wire [15:0] i_bus_voltage,
   output wire [9:0]  o_analog_out_a,
   output wire [9:0]  o_analog_out_b,
   output reg         o_pulse_reverse
);
   // inputs are signed q1.15 of their maxima; pulse frequency and bus voltage
   // arrive as unsigned fractions of 4.5 Mpps and 450 V
   reg [15:0] src_q;
   reg [15:0] pol_q;
   reg [15:0] prop_a_q;
   reg [15:0] prop_b_q;
   reg [15:0] drift_a_q;
   reg [15:0] drift_b_q;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         src_q     <= `AMO_RST_SRC;
         pol_q     <= `AMO_RST_POL;
         prop_a_q  <= `AMO_RST_PROP;
         prop_b_q  <= `AMO_RST_PROP;
         drift_a_q <= `AMO_RST_DRIFT;
         drift_b_q <= `AMO_RST_DRIFT;
      end else if (i_param_reset) begin
         src_q    <= `AMO_RST_SRC;
         pol_q    <= `AMO_RST_POL;
         prop_a_q <= `AMO_RST_PROP;
         prop_b_q <= `AMO_RST_PROP;
         // drift calibration survives a keep-calibration reset
         if (i_param_reset_value != `AMO_KEEP_DRIFT) begin
            drift_a_q <= `AMO_RST_DRIFT;
            drift_b_q <= `AMO_RST_DRIFT;
         end
      end else if (i_par_wr) begin
         if (i_par_addr == `AMO_ADDR_SRC)
            src_q <= i_par_wdata;
         else if (i_par_addr == `AMO_ADDR_POL)
            pol_q <= i_par_wdata;
         else if (i_par_addr == `AMO_ADDR_PROP_A)
            prop_a_q <= i_par_wdata;
         else if (i_par_addr == `AMO_ADDR_PROP_B)
            prop_b_q <= i_par_wdata;
         else if (i_par_addr == `AMO_ADDR_DRIFT_A)
            drift_a_q <= i_par_wdata;
         else if (i_par_addr == `AMO_ADDR_DRIFT_B)
            drift_b_q <= i_par_wdata;
      end
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_par_rdata     <= `AMO_RST_RDATA;
         o_pulse_reverse <= 1'b0;
      end else begin
         o_pulse_reverse <= pol_q[`AMO_POL_PULSE];
         if (i_par_addr == `AMO_ADDR_SRC)
            o_par_rdata <= src_q;
         else if (i_par_addr == `AMO_ADDR_POL)
            o_par_rdata <= pol_q;
         else if (i_par_addr == `AMO_ADDR_PROP_A)
            o_par_rdata <= prop_a_q;
         else if (i_par_addr == `AMO_ADDR_PROP_B)
            o_par_rdata <= prop_b_q;
         else if (i_par_addr == `AMO_ADDR_DRIFT_A)
            o_par_rdata <= drift_a_q;
         else if (i_par_addr == `AMO_ADDR_DRIFT_B)
            o_par_rdata <= drift_b_q;
         else
            o_par_rdata <= `AMO_RST_RDATA;
      end
   end

   function [15:0] amo_pick;
      input [2:0]  sel;
      input [15:0] spd;
      input [15:0] trq;
      input [15:0] pls;
      input [15:0] scmd;
      input [15:0] tcmd;
      input [15:0] vbus;
      begin
         case (sel)
            `AMO_SRC_SPEED:   amo_pick = spd;
            `AMO_SRC_TORQUE:  amo_pick = trq;
            `AMO_SRC_PULSE:   amo_pick = {1'b0, pls[15:1]};
            `AMO_SRC_SPD_CMD: amo_pick = scmd;
            `AMO_SRC_TRQ_CMD: amo_pick = tcmd;
            `AMO_SRC_VBUS:    amo_pick = {1'b0, vbus[15:1]};
            default:          amo_pick = `AMO_NORM_ZERO;
         endcase
      end
   endfunction

   // channel 0 is a, channel 1 is b in every vector below
   wire [1:0]  invert_vec;
   wire [31:0] prop_vec;
   wire [31:0] drift_vec;
   wire [19:0] code_vec;

   assign invert_vec = {pol_q[`AMO_POL_INV_B], pol_q[`AMO_POL_INV_A]};
   assign prop_vec   = {prop_b_q, prop_a_q};
   assign drift_vec  = {drift_b_q, drift_a_q};

   genvar ch;
   generate
      for (ch = 0; ch < `AMO_CHANNELS; ch = ch + 1) begin : g_chan
         wire [15:0] norm;

         // each channel reads its own hex digit of the source register
         assign norm = amo_pick(src_q[ch*`AMO_SRC_DIGIT_W +: `AMO_SRC_SEL_W], i_motor_speed, i_motor_torque,
                                i_pulse_freq, i_speed_cmd, i_torque_cmd, i_bus_voltage);

         amo_channel u_chan (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .i_norm     (norm),
            .i_invert   (invert_vec[ch]),
            .i_prop     (prop_vec[ch*`AMO_REG_W +: `AMO_REG_W]),
            .i_drift    (drift_vec[ch*`AMO_REG_W +: `AMO_REG_W]),
            .o_code     (code_vec[ch*`AMO_CODE_W +: `AMO_CODE_W])
         );
      end
   endgenerate

   assign o_analog_out_a = code_vec[9:0];
   assign o_analog_out_b = code_vec[19:10];
endmodule

// *** verif/amo_monitor_asserts.sv ***
`timescale 1ns/1ps
module amo_monitor_asserts (
   input wire        i_core_clk,
   input wire        i_rst,
   input wire        i_par_wr,
   input wire [15:0] i_par_addr,
   input wire [15:0] i_par_wdata,
   input wire [15:0] o_par_rdata,
   input wire        i_param_reset,
   input wire [15:0] i_param_reset_value,
   input wire [15:0] i_motor_speed,
   input wire [15:0] i_motor_torque,
   input wire [15:0] i_pulse_freq,
   input wire [15:0] i_speed_cmd,
   input wire [15:0] i_torque_cmd,
   input wire [15:0] i_bus_voltage,
   input wire [9:0]  o_analog_out_a,
   input wire [9:0]  o_analog_out_b,
   input wire        o_pulse_reverse
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   wire quiet = !i_par_wr && !i_param_reset;
   wire mapped = i_par_addr inside {16'h0006, 16'h0106, 16'h0108, 16'h010a, 16'h0428, 16'h042a};
   wire [95:0] srcs = {i_motor_speed, i_motor_torque, i_pulse_freq, i_speed_cmd, i_torque_cmd, i_bus_voltage};
   sequence s_at(a); i_par_addr == a && quiet; endsequence
   sequence s_wr(a); i_par_wr && !i_param_reset && i_par_addr == a; endsequence
   chk_pulse_dir: assert property (s_wr(16'h0106) ##1 s_at(16'h0106) |=> o_pulse_reverse == $past(i_par_wdata[4], 2))
      else $error("pulse direction not taken from polarity write");
   chk_pulse_cause: assert property ($changed(o_pulse_reverse) |-> $past(i_par_wr, 2) || $past(i_param_reset, 2))
      else $error("pulse direction changed without cause");
   chk_unmapped_zero: assert property (!mapped |=> o_par_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_prop_write: assert property (
      s_wr(16'h010a) ##1 s_at(16'h010a) |=> o_par_rdata == $past(i_par_wdata, 2))
      else $error("proportion b readback wrong");
   chk_prop_default: assert property (
      i_param_reset && !i_par_wr && i_par_addr == 16'h0108 ##1 s_at(16'h0108) |=> o_par_rdata == 16'h0064)
      else $error("proportion a not restored");
   chk_drift_kept: assert property (
      s_at(16'h0428) ##1 (i_param_reset && i_param_reset_value == 16'h000a && !i_par_wr
      && i_par_addr == 16'h0428) ##1 s_at(16'h0428) [*2] |-> o_par_rdata == $past(o_par_rdata, 2))
      else $error("drift offset lost on keep reset");
   chk_drift_clear: assert property (
      i_param_reset && i_param_reset_value != 16'h000a && !i_par_wr
      && i_par_addr == 16'h042a ##1 s_at(16'h042a) |=> o_par_rdata == 16'h0000)
      else $error("drift offset not cleared");
   chk_code_hold: assert property ((quiet && $stable(srcs)) [*3] |=> $stable({o_analog_out_a, o_analog_out_b}))
      else $error("converter code moved with no cause");
endmodule
bind amo_monitor amo_monitor_asserts u_chk (.*);

// *** verif/amo_dac_model.sv ***
`timescale 1ns/1ps
module amo_dac_model (
   input  wire [9:0] i_code_a,
   input  wire [9:0] i_code_b,
   output int        o_mv_a,
   output int        o_mv_b
);
   // offset binary, mid code is 0 v; pins are never driven past the rails
   assign o_mv_a = (int'(i_code_a) - 512) * 8000 / 512;
   assign o_mv_b = (int'(i_code_b) - 512) * 8000 / 512;
endmodule

// *** verif/test_analog_monitor_output_ctrl.sv ***
`timescale 1ns/1ps
module test_analog_monitor_output_ctrl;
   logic        i_core_clk = 0, i_rst = 1, i_par_wr = 0, i_param_reset = 0;
   logic [15:0] i_par_addr = 0, i_par_wdata = 0, i_param_reset_value = 0, i_motor_speed = 0, i_motor_torque = 0;
   logic [15:0] i_pulse_freq = 0, i_speed_cmd = 0, i_torque_cmd = 0, i_bus_voltage = 0;
   wire  [15:0] o_par_rdata;
   wire  [9:0]  o_analog_out_a, o_analog_out_b;
   wire         o_pulse_reverse;
   int          mv_a, mv_b, n_fail = 0, total_checks = 0;
   logic [9:0]  exp_src [6] = '{10'h3ff, 10'h000, 10'h2ff, 10'h27f, 10'h180, 10'h37f};
   amo_monitor u_dut (.*);
   amo_dac_model u_dac (.i_code_a(o_analog_out_a), .i_code_b(o_analog_out_b), .o_mv_a(mv_a), .o_mv_b(mv_b));
   initial forever #50 i_core_clk = ~i_core_clk;
   task automatic chk(input string n, input logic [15:0] seen, exp, input int tol);
      int d;
      d = int'(seen) - int'(exp);
      total_checks++;
      if (^seen === 1'bx || d > tol || d < -tol) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic chk_mv(input string n, input int seen, exp, tol);
      total_checks++;
      if (seen > exp + tol || seen < exp - tol) begin
         n_fail++;
         $display("BAD %s expected %0d seen %0d", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, d);
      @(posedge i_core_clk);
      i_par_wr <= 1;
      i_par_addr <= a;
      i_par_wdata <= d;
      @(posedge i_core_clk);
      i_par_wr <= 0;
   endtask
   task automatic rd(input logic [15:0] a, exp);
      @(posedge i_core_clk);
      i_par_addr <= a;
      repeat (2) @(posedge i_core_clk);
      #1 chk("rdata", o_par_rdata, exp, 0);
   endtask
   // rounding of the mv to code step is the designer's, so codes get one step of slack
   task automatic code(input logic [9:0] ea, eb);
      repeat (3) @(posedge i_core_clk);
      #1 chk("code_a", {6'h0, o_analog_out_a}, {6'h0, ea}, 1);
      chk("code_b", {6'h0, o_analog_out_b}, {6'h0, eb}, 1);
   endtask
   task automatic prst(input logic [15:0] v);
      @(posedge i_core_clk);
      i_param_reset <= 1;
      i_param_reset_value <= v;
      @(posedge i_core_clk);
      i_param_reset <= 0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #200000 n_fail++;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_rst <= 0;
      foreach (exp_src[i]) rd(16'h0006 + 16'(i / 6), 16'h0000);
      rd(16'h0106, 16'h0000);
      rd(16'h010a, 16'h0064);
      rd(16'h0200, 16'h0000);
      @(posedge i_core_clk);
      i_motor_speed <= 16'h7fff;
      i_motor_torque <= 16'h8000;
      i_pulse_freq <= 16'h8000;
      i_speed_cmd <= 16'h2000;
      i_torque_cmd <= 16'he000;
      i_bus_voltage <= 16'hc000;
      for (int s = 0; s < 6; s++) begin
         wr(16'h0006, 16'h0060 | 16'(s));
         code(exp_src[s], 10'h200);
         wr(16'h0006, 16'(s << 4) | 16'h0007);
         code(10'h200, exp_src[s]);
      end
      wr(16'h0006, 16'h0000);
      for (int p = 0; p < 4; p++) begin
         wr(16'h0106, 16'(p));
         code(p[1] ? 10'h000 : 10'h3ff, p[0] ? 10'h000 : 10'h3ff);
      end
      wr(16'h0106, 16'h0010);
      code(10'h3ff, 10'h3ff);
      chk("pulse", {15'h0, o_pulse_reverse}, 16'h0001, 0);
      @(posedge i_core_clk);
      i_motor_speed <= 16'h2000;
      wr(16'h0108, 16'h0032);
      code(10'h2ff, 10'h27f);
      wr(16'h0108, 16'h0019);
      wr(16'h010a, 16'h000a);
      code(10'h3ff, 10'h3ff);
      chk_mv("mv_b", mv_b, 8000, 16);
      rd(16'h010a, 16'h000a);
      rd(16'h0108, 16'h0019);
      prst(16'h0000);
      rd(16'h0108, 16'h0064);
      chk("pulse", {15'h0, o_pulse_reverse}, 16'h0000, 0);
      @(posedge i_core_clk);
      i_motor_speed <= 16'h0000;
      wr(16'h0428, 16'h0320);
      wr(16'h042a, 16'hfce0);
      code(10'h233, 10'h1cc);
      chk_mv("mv_a", mv_a, 800, 16);
      chk_mv("mv_b", mv_b, -800, 16);
      @(posedge i_core_clk);
      i_motor_speed <= 16'h7fff;
      code(10'h3ff, 10'h3cc);
      rd(16'h0428, 16'h0320);
      prst(16'h000a);
      rd(16'h0428, 16'h0320);
      rd(16'h042a, 16'hfce0);
      prst(16'h0001);
      rd(16'h042a, 16'h0000);
      // zero proportion rails the output; over-range proportion and drift are limited
      @(posedge i_core_clk);
      i_motor_speed <= 16'h0100;
      wr(16'h0108, 16'h0000);
      wr(16'h010a, 16'h00c8);
      wr(16'h042a, 16'h03e8);
      code(10'h3ff, 10'h237);
      stop_test;
   end
endmodule
